// ==== src/csp_params.svh ====
// Register map, field positions, reset values and counts of the serial port
`ifndef CSP_PARAMS_SVH
`define CSP_PARAMS_SVH
`define CSP_OFF_TXBUF   8'h00
`define CSP_OFF_RXBUF   8'h04
`define CSP_OFF_BRG     8'h08
`define CSP_OFF_MODE    8'h0C
`define CSP_OFF_CTRL0   8'h10
`define CSP_OFF_CTRL1   8'h14
`define CSP_OFF_SHARED  8'h18
`define CSP_OFF_CLKSRC  8'h1C
`define CSP_MODE_OFF    3'b000
`define CSP_MODE_SYNC   3'b001
`define CSP_MODE_CLOCK_DIRECTION_SELECT  3
`define CSP_C0_FLOWSEL  2
`define CSP_C0_SREMPTY  3
`define CSP_C0_FLOWDIS  4
`define CSP_C0_ODSEL    5
`define CSP_C0_CPOL     6
`define CSP_C0_MSB      7
`define CSP_C1_TXEN     0
`define CSP_C1_TBEMPTY  1
`define CSP_C1_RXEN     2
`define CSP_C1_RXDONE   3
`define CSP_C1_IRQSRC   4
`define CSP_C1_CONTRX   5
`define CSP_C1_INVERT   6
`define CSP_SH_PINSEL   0
`define CSP_SH_DUALCK   1
`define CSP_SH_FLOWSEP  2
`define CSP_CS_SRCLO    0
`define CSP_CS_SRCHI    1
`define CSP_CS_CNTSRC   2
`define CSP_RB_OVR      12
`define CSP_RST_BYTE    8'h00
`define CSP_LAST_BIT    3'h7
`endif

// ==== src/csp_pkg.sv ====
// Types shared by the serial port modules
package csp_pkg;
  typedef enum logic [0:0] {
    csp_st_idle  = 1'b0,
    csp_st_shift = 1'b1
  } csp_state_t;
endpackage : csp_pkg

// ==== src/csp_brg_if.sv ====
// Link between the transfer engine and the bit-rate divider
`timescale 1ns/1ps
interface csp_brg_if #(parameter int W = 8) ();
  logic         en;
  logic         src_tick;
  logic [W-1:0] n;
  logic         half_tick;
  modport ctl (output en, output src_tick, output n, input half_tick);
  modport div (input en, input src_tick, input n, output half_tick);
endinterface : csp_brg_if

// ==== src/csp_brg_div.sv ====
// Bit-rate divider: one half-period tick every n+1 source ticks
`timescale 1ns/1ps
module csp_brg_div (
  // Clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rstn,
  // Divider link
  csp_brg_if.div    brg
);
  logic [$bits(brg.n)-1:0] cnt_r;
  logic                    tick_r;

  // Count source ticks, restart on each half period
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn || !brg.en) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else if (brg.src_tick) begin
      if (cnt_r == brg.n) begin // RL20
        cnt_r  <= '0;
        tick_r <= 1'b1;
      end else begin
        cnt_r  <= cnt_r + 1'b1;
        tick_r <= 1'b0;
      end
    end else begin
      tick_r <= 1'b0;
    end
  end

  assign brg.half_tick = tick_r;
endmodule : csp_brg_div

// ==== src/csp_port.sv ====
// Clocked serial port channel with pin muxing and Wishbone registers
// Functional notes
// (RL1) External clock must idle high with polarity 0, low with 1.
// (RL2) Overrun leaves receive data undefined and raises no receive event.
// (RL3) Data out idles high until transfer; released when open-drain.
// (RL4) Receive-only transfers still shift dummy data out.
// (RL5) Clock pin drives when direction is 0, is input when 1.
// (RL6) Flow pin: CTS in, RTS out, or general port per control bits.
// (RL7) Separation routes shared pin to channel 0 CTS; channel 0 uses RTS.
// (RL8) Dual clock with pin select 0 holds unused pin at idle level.
// (RL9) Dual clock lets channel 1 clock from two pins, select picks one.
// (RL10) Receive buffer: data bits 0-7, undefined bits read 0, overrun flag.
// (RL11) Transmit enable needed for any transfer, receive enable to receive.
// (RL12) Shift-empty, buffer-empty and receive-done flags are readable.
// (RL13) Continuous-receive bit selects continuous receive mode.
// (RL14) Inversion bit inverts transmitted and received data.
// (RL15) Per-channel bit picks the transmit event source.
// (RL16) Channel 2 data out always open-drain; its select bit reads 0.
// (RL17) Software sets port direction to input for input pins.
// (RL18) Source select per channel group, plus counter source select.
// (RL19) Mode 001b is clocked serial, 000b disables the port.
// (RL20) Internal clock rate is source over 2(n+1).
// (RL21) Transmit event on buffer load or on shift completion.
// (RL22) Continuous receive: buffer read clears buffer-empty flag.
`timescale 1ns/1ps
`include "csp_params.svh"
module csp_port #(
  parameter int CHAN_ID = 1
) (
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rstn,
  // Wishbone slave
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [31:0] i_wb_dat,
  input  wire logic [3:0]  i_wb_sel,
  output wire logic [31:0] o_wb_dat,
  output wire logic        o_wb_ack,
  // Serial data pins
  output wire logic        o_txd_o,
  output wire logic        o_txd_oe,
  input  wire logic        i_rxd,
  // Transfer clock pin
  input  wire logic        i_clk_i,
  output wire logic        o_clk_o,
  output wire logic        o_clk_oe,
  // Flow control or shared pin
  input  wire logic        i_flow_i,
  output wire logic        o_flow_o,
  output wire logic        o_flow_oe,
  // Alternate source clock pulse
  input  wire logic        i_alt_src_pulse,
  // Shared pin separation between channels
  input  wire logic        i_sep_active,
  input  wire logic        i_sep_cts_n,
  output wire logic        o_sep_active,
  output wire logic        o_ch0_cts_n,
  // Transfer events
  output wire logic        o_tx_evt,
  output wire logic        o_rx_evt
);
  localparam bit IS_CH0 = (CHAN_ID == 0);
  localparam bit IS_CH1 = (CHAN_ID == 1);
  localparam bit IS_CH2 = (CHAN_ID == 2);
  localparam bit LOW_GRP = (CHAN_ID < 3);

  csp_brg_if #(.W(8)) brg ();
  csp_pkg::csp_state_t st_r;
  logic [7:0]  tb_r, rb_r, brg_r, mode_r, c0_r, c1_r, sh_r, cs_r;
  logic [7:0]  tx_sh_r, rx_sh_r, rx_nxt;
  logic [2:0]  bit_cnt_r;
  logic [4:0]  pre_cnt_r, pre_mask;
  logic [31:0] rd_nxt, rd_r;
  logic        ack_r, req, wr, rb_rd, tb_wr;
  logic        rxd_s1_r, rxd_s2_r, clk_s1_r, clk_s2_r, clk_s3_r;
  logic        flw_s1_r, flw_s2_r;
  logic        ti_r, ri_r, ovr_r, sclk_r, txd_r, rts_n_r;
  logic        tx_evt_r, rx_evt_r;
  logic        mode_on, int_clk, idle_lvl, msb, inv, od, dual, sep;
  logic        base, lead, trail, cts_sel, cts_n, cts_ok;
  logic        start, done, ovr_set, rx_set, busy;

  // Register fields
  assign mode_on  = (mode_r[2:0] == `CSP_MODE_SYNC); // RL19
  assign int_clk  = ~mode_r[`CSP_MODE_CLOCK_DIRECTION_SELECT];
  assign idle_lvl = ~c0_r[`CSP_C0_CPOL];
  assign msb      = c0_r[`CSP_C0_MSB];
  assign inv      = c1_r[`CSP_C1_INVERT];
  assign od       = IS_CH2 | c0_r[`CSP_C0_ODSEL]; // RL16
  assign dual     = IS_CH1 & sh_r[`CSP_SH_DUALCK]; // RL9
  assign sep      = IS_CH1 & sh_r[`CSP_SH_FLOWSEP] & ~dual;
  assign busy     = (st_r == csp_pkg::csp_st_shift);

  // Bus handshake: ack one cycle after request, effects at the ack edge
  assign req   = i_wb_cyc & i_wb_stb;
  assign wr    = req & i_wb_we & ack_r & i_wb_sel[0];
  assign rb_rd = req & ~i_wb_we & ack_r & (i_wb_adr == `CSP_OFF_RXBUF);
  assign tb_wr = wr & (i_wb_adr == `CSP_OFF_TXBUF);

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      ack_r <= 1'b0;
      rd_r  <= 32'h0000_0000;
    end else begin
      ack_r <= req & ~ack_r;
      rd_r  <= rd_nxt;
    end
  end

  // Read decode; unmapped and write-only offsets read zero
  always_comb begin
    rd_nxt = 32'h0000_0000;
    unique case (i_wb_adr)
      `CSP_OFF_RXBUF: begin
        rd_nxt[7:0]         = rb_r; // RL10
        rd_nxt[`CSP_RB_OVR] = ovr_r; // RL10
      end
      `CSP_OFF_BRG:    rd_nxt[7:0] = brg_r;
      `CSP_OFF_MODE:   rd_nxt[7:0] = mode_r;
      `CSP_OFF_CTRL0: begin
        rd_nxt[7:0]             = c0_r;
        rd_nxt[`CSP_C0_SREMPTY] = ~busy; // RL12
        rd_nxt[`CSP_C0_ODSEL]   = c0_r[`CSP_C0_ODSEL] & ~IS_CH2; // RL16
      end
      `CSP_OFF_CTRL1: begin
        rd_nxt[7:0]             = c1_r;
        rd_nxt[`CSP_C1_TBEMPTY] = ti_r; // RL12
        rd_nxt[`CSP_C1_RXDONE]  = ri_r; // RL12
      end
      `CSP_OFF_SHARED: rd_nxt[7:0] = sh_r;
      `CSP_OFF_CLKSRC: rd_nxt[7:0] = cs_r;
      default:         rd_nxt = 32'h0000_0000;
    endcase
  end

  // Software-written registers
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      tb_r   <= `CSP_RST_BYTE;
      brg_r  <= `CSP_RST_BYTE;
      mode_r <= `CSP_RST_BYTE;
      c0_r   <= `CSP_RST_BYTE;
      c1_r   <= `CSP_RST_BYTE;
      sh_r   <= `CSP_RST_BYTE;
      cs_r   <= `CSP_RST_BYTE;
    end else if (wr) begin
      unique case (i_wb_adr)
        `CSP_OFF_TXBUF:  tb_r   <= i_wb_dat[7:0];
        `CSP_OFF_BRG:    brg_r  <= i_wb_dat[7:0];
        `CSP_OFF_MODE:   mode_r <= i_wb_dat[7:0];
        `CSP_OFF_CTRL0:  c0_r   <= i_wb_dat[7:0];
        `CSP_OFF_CTRL1:  c1_r   <= i_wb_dat[7:0];
        `CSP_OFF_SHARED: sh_r   <= i_wb_dat[7:0];
        `CSP_OFF_CLKSRC: cs_r   <= i_wb_dat[7:0];
        default:         tb_r   <= tb_r;
      endcase
    end
  end

  // Pin synchronisers
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      rxd_s1_r <= 1'b1;
      rxd_s2_r <= 1'b1;
      clk_s1_r <= 1'b1;
      clk_s2_r <= 1'b1;
      clk_s3_r <= 1'b1;
      flw_s1_r <= 1'b1;
      flw_s2_r <= 1'b1;
    end else begin
      rxd_s1_r <= i_rxd;
      rxd_s2_r <= rxd_s1_r;
      clk_s1_r <= i_clk_i;
      clk_s2_r <= clk_s1_r;
      clk_s3_r <= clk_s2_r;
      flw_s1_r <= i_flow_i;
      flw_s2_r <= flw_s1_r;
    end
  end

  // Source clock choice and pre-division by 1, 2, 8 or 32
  assign base = ~cs_r[`CSP_CS_CNTSRC] | i_alt_src_pulse |
                ~(LOW_GRP ? cs_r[`CSP_CS_SRCLO]
                          : cs_r[`CSP_CS_SRCHI]); // RL18
  always_comb begin
    unique case (c0_r[1:0])
      2'h0: pre_mask = 5'h00;
      2'h1: pre_mask = 5'h01;
      2'h2: pre_mask = 5'h07;
      2'h3: pre_mask = 5'h1F;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      pre_cnt_r <= 5'h00;
    end else if (base) begin
      pre_cnt_r <= pre_cnt_r + 5'h01;
    end
  end

  // Divider runs only during internally clocked transfers
  assign brg.en       = int_clk & busy;
  assign brg.src_tick = base & ((pre_cnt_r & pre_mask) == pre_mask);
  assign brg.n        = brg_r;

  csp_brg_div u_div (
    .i_ref_clk (i_ref_clk),
    .i_rstn    (i_rstn),
    .brg       (brg)
  );

  // Clock edges: leading shifts out, trailing samples
  assign lead  = int_clk ? (brg.half_tick & (sclk_r == idle_lvl))
                         : ((clk_s3_r == idle_lvl) &
                            (clk_s2_r != idle_lvl)); // RL5
  assign trail = int_clk ? (brg.half_tick & (sclk_r != idle_lvl))
                         : ((clk_s3_r != idle_lvl) &
                            (clk_s2_r == idle_lvl)); // RL5

  // Start and finish of a frame
  assign cts_sel = ~c0_r[`CSP_C0_FLOWDIS] & (~c0_r[`CSP_C0_FLOWSEL] |
                   (IS_CH0 & i_sep_active)); // RL7
  assign cts_n   = (IS_CH0 & i_sep_active) ? i_sep_cts_n : flw_s2_r; // RL7
  assign cts_ok  = ~cts_sel | ~cts_n; // RL6
  assign start   = mode_on & ~busy & c1_r[`CSP_C1_TXEN] & ~ti_r
                   & cts_ok; // RL11
  assign done    = busy & trail & (bit_cnt_r == `CSP_LAST_BIT);
  assign rx_nxt  = msb ? {rx_sh_r[6:0], rxd_s2_r}
                       : {rxd_s2_r, rx_sh_r[7:1]};
  assign ovr_set = done & c1_r[`CSP_C1_RXEN] & ri_r & ~rb_rd; // RL2
  assign rx_set  = done & c1_r[`CSP_C1_RXEN] & ~ovr_set; // RL11

  // Transfer engine
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      st_r      <= csp_pkg::csp_st_idle;
      bit_cnt_r <= 3'h0;
      tx_sh_r   <= 8'h00;
      rx_sh_r   <= 8'h00;
      sclk_r    <= 1'b1;
      txd_r     <= 1'b1;
    end else if (!mode_on) begin
      st_r      <= csp_pkg::csp_st_idle; // RL19
      bit_cnt_r <= 3'h0;
      sclk_r    <= idle_lvl;
      txd_r     <= 1'b1;
    end else begin
      unique case (st_r)
        csp_pkg::csp_st_idle: begin
          sclk_r <= idle_lvl;
          txd_r  <= 1'b1; // RL3
          if (start) begin
            tx_sh_r   <= tb_r;
            bit_cnt_r <= 3'h0;
            st_r      <= csp_pkg::csp_st_shift;
          end
        end
        csp_pkg::csp_st_shift: begin
          if (lead) begin
            // Buffer bits go out even when only receiving
            txd_r   <= (msb ? tx_sh_r[7] : tx_sh_r[0]) ^ inv; // RL4 RL14
            tx_sh_r <= msb ? {tx_sh_r[6:0], 1'b0}
                           : {1'b0, tx_sh_r[7:1]};
            if (int_clk) begin
              sclk_r <= ~idle_lvl;
            end
          end
          if (trail) begin
            rx_sh_r   <= rx_nxt;
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (int_clk) begin
              sclk_r <= idle_lvl;
            end
            if (bit_cnt_r == `CSP_LAST_BIT) begin
              st_r <= csp_pkg::csp_st_idle;
            end
          end
        end
      endcase
    end
  end

  // Status flags; hardware set wins over software clear
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn || !mode_on) begin
      ti_r <= 1'b1;
    end else if (start) begin
      ti_r <= 1'b1;
    end else if (tb_wr || (rb_rd && c1_r[`CSP_C1_CONTRX])) begin
      ti_r <= 1'b0; // RL13 RL22
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn || !mode_on) begin
      ri_r <= 1'b0;
    end else if (rx_set) begin
      ri_r <= 1'b1;
    end else if (rb_rd) begin
      ri_r <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn || !mode_on || !c1_r[`CSP_C1_RXEN]) begin
      ovr_r <= 1'b0;
    end else if (ovr_set) begin
      ovr_r <= 1'b1; // RL10
    end
  end

  // Receive buffer, overwritten on overrun
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      rb_r <= 8'h00;
    end else if (done && c1_r[`CSP_C1_RXEN]) begin
      rb_r <= rx_nxt ^ {8{inv}}; // RL2 RL14
    end
  end

  // Event pulses and ready-to-receive level
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      tx_evt_r <= 1'b0;
      rx_evt_r <= 1'b0;
      rts_n_r  <= 1'b1;
    end else begin
      tx_evt_r <= c1_r[`CSP_C1_IRQSRC] ? done : start; // RL15 RL21
      rx_evt_r <= rx_set; // RL2
      rts_n_r  <= ~(mode_on & c1_r[`CSP_C1_RXEN] & ~ri_r);
    end
  end

  // Data out pin
  assign o_txd_o  = od ? 1'b0 : txd_r;
  assign o_txd_oe = mode_on & (od ? ~txd_r : 1'b1); // RL3

  // Clock pin, idle level when the second pin carries the clock
  assign o_clk_o  = (dual & sh_r[`CSP_SH_PINSEL]) ? idle_lvl : sclk_r;
  assign o_clk_oe = mode_on & int_clk; // RL5

  // Flow pin: second clock, separated CTS, RTS out or released port
  assign o_flow_o  = dual ? (sh_r[`CSP_SH_PINSEL] ? sclk_r
                                                  : idle_lvl) // RL8
                          : rts_n_r;
  assign o_flow_oe = mode_on & (dual | (~sep & ~c0_r[`CSP_C0_FLOWDIS]
                                        & c0_r[`CSP_C0_FLOWSEL])); // RL6
  assign o_sep_active = sep; // RL7
  assign o_ch0_cts_n  = sep ? flw_s2_r : 1'b1; // RL7

  assign o_wb_dat = rd_r;
  assign o_wb_ack = ack_r;
  assign o_tx_evt = tx_evt_r;
  assign o_rx_evt = rx_evt_r;

  // Checks
  a_ovr_no_event: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    ovr_set |=> !o_rx_evt && ri_r) else $error("overrun raised rx event"); // RL2
  a_txd_idle_high: assert property (@(posedge i_ref_clk)
    disable iff (!i_rstn) (mode_on && !busy && $past(!busy) && !od)
    |-> o_txd_o && o_txd_oe) else $error("txd not high at idle"); // RL3
  a_txd_od_release: assert property (@(posedge i_ref_clk)
    disable iff (!i_rstn) (od && txd_r) |-> !o_txd_oe)
    else $error("open-drain txd driven high"); // RL16
  a_clk_dir: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    mode_on |-> (o_clk_oe == int_clk)) else $error("clock pin dir"); // RL5
  a_dual_fixed: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (mode_on && dual && !sh_r[`CSP_SH_PINSEL]) |->
    (o_flow_oe && o_flow_o == idle_lvl)) else $error("unused clk pin"); // RL8
  a_start_needs_te: assert property (@(posedge i_ref_clk)
    disable iff (!i_rstn) start |-> c1_r[`CSP_C1_TXEN] ##1 busy && ti_r)
    else $error("start without enable"); // RL11
  a_contrx_clear: assert property (@(posedge i_ref_clk)
    disable iff (!i_rstn) (mode_on && rb_rd && c1_r[`CSP_C1_CONTRX]
    && !start) |=> !ti_r) else $error("read did not clear flag"); // RL22
  a_tx_event_src: assert property (@(posedge i_ref_clk)
    disable iff (!i_rstn) (start && !c1_r[`CSP_C1_IRQSRC]) |=> o_tx_evt)
    else $error("tx event missing at load"); // RL21
  a_frame_bits: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    done |-> bit_cnt_r == `CSP_LAST_BIT ##1 !busy)
    else $error("frame length wrong"); // RL12
endmodule : csp_port

// ==== verif/csp_peer.sv ====
// Clocked serial peer: polarity 0, lsb first, clock made by the port
`timescale 1ns/1ps
module csp_peer (
  // Link pins
  input  wire logic       i_rstn,
  input  wire logic       i_sclk,
  input  wire logic       i_txd,
  output logic            o_rxd,
  // Frame data
  input  wire logic [7:0] i_byte,
  output logic      [7:0] o_got,
  output int              o_frames
);
  int         cnt = 0;
  logic [7:0] sh;
  // Line idles high until the first frame
  initial o_rxd = 1'b1;
  // Next bit leaves on the leading (falling) edge
  always @(negedge i_sclk) begin
    if (i_rstn) begin
      o_rxd <= i_byte[cnt[2:0]];
    end
  end
  // Sample on the trailing edge, count whole frames
  always @(posedge i_sclk) begin
    if (!i_rstn) begin
      cnt = 0;
    end else begin
      sh = {i_txd, sh[7:1]};
      cnt++;
      if (cnt == 8) begin
        cnt = 0;
        o_got <= sh;
        o_frames <= o_frames + 1;
        o_rxd <= ~o_rxd; // Released line shows the inverse
      end
    end
  end
endmodule : csp_peer

// ==== verif/tb.sv ====
// Self-checking bench for the clocked serial port channel
`timescale 1ns/1ps
`include "csp_params.svh"
module tb;
  typedef struct {
    logic [31:0] e;
    logic [31:0] m;
  } csp_note_t;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic             clk, rstn, cyc, stb, we, flow_i, ext_ck;
  logic [7:0]       adr, pb, t, r;
  logic [31:0]      wdat, got;
  logic [3:0]       sel;
  logic [15:0]      seed;
  wire logic        ack, txd, txd_oe, sclk, clk_oe, flow_o, flow_oe;
  wire logic        sep_o, cts0_n, tx_evt, rx_evt, rxd;
  wire logic [31:0] rdat;
  wire logic [7:0]  pgot;
  int               pfr, miscompares, num_checks, cycles, rx_evts;
  int               evt_fr, t_fall, per, n0, k;
  csp_note_t        q[$];
  csp_note_t        x;

  csp_port #(.CHAN_ID(1)) dut_u (
    .i_ref_clk(clk), .i_rstn(rstn),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_dat(rdat), .o_wb_ack(ack),
    .o_txd_o(txd), .o_txd_oe(txd_oe), .i_rxd(rxd),
    .i_clk_i(ext_ck), .o_clk_o(sclk), .o_clk_oe(clk_oe),
    .i_flow_i(flow_i), .o_flow_o(flow_o), .o_flow_oe(flow_oe),
    .i_alt_src_pulse(1'b0), .i_sep_active(1'b0), .i_sep_cts_n(1'b1),
    .o_sep_active(sep_o), .o_ch0_cts_n(cts0_n),
    .o_tx_evt(tx_evt), .o_rx_evt(rx_evt)
  );
  csp_peer peer_u (
    .i_rstn(rstn), .i_sclk(sclk), .i_txd(txd), .o_rxd(rxd),
    .i_byte(pb), .o_got(pgot), .o_frames(pfr)
  );

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask : check

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict

  // One classic cycle, held until ack is sampled
  task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= {24'h0, d};
    sel  <= 4'hF;
    do @(posedge clk); while (ack !== 1'b1);
    got = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    sel <= 4'h0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb(a, 1'b1, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    q.push_back('{e, m});
    wb(a, 1'b0, 8'h00);
  endtask : rd

  // Wait for the frame, then for the shift register to empty
  task automatic fin();
    wait (pfr > n0);
    do wb(`CSP_OFF_CTRL0, 1'b0, 8'h00); while ((got & 32'h8) == 0);
    repeat (2) @(posedge clk);
  endtask : fin

  task automatic xfer();
    seed = lfsr(seed);
    t = seed[7:0];
    r = seed[15:8];
    pb <= r;
    n0 = pfr;
    wr(`CSP_OFF_TXBUF, t);
    fin();
  endtask : xfer

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Cycle count and hang limit
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      give_verdict();
    end
  end
  // Read data against the oldest note, event watch
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0 && q.size() > 0) begin
      x = q.pop_front();
      check(rdat & x.m, x.e);
    end
    if (tx_evt === 1'b1) evt_fr = pfr;
    if (rx_evt === 1'b1) rx_evts++;
  end
  // Clock period from successive leading edges
  always @(negedge sclk) begin
    per = cycles - t_fall;
    t_fall = cycles;
  end

  initial begin
    {rstn, cyc, stb, we, adr, wdat, sel, pb} = '0;
    flow_i = 1'b1;
    ext_ck = 1'b1;
    evt_fr = -1;
    seed = 16'hE221;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    check(32'(txd_oe), 32'h0);
    rd(`CSP_OFF_CTRL1, 32'h2, ALL);
    rd(`CSP_OFF_TXBUF, 32'h0, ALL);
    rd(8'h20, 32'h0, ALL);
    wr(`CSP_OFF_CLKSRC, 8'h07);
    rd(`CSP_OFF_CLKSRC, 32'h7, ALL);
    wr(`CSP_OFF_CLKSRC, 8'h00);
    wr(`CSP_OFF_BRG, 8'h04);
    rd(`CSP_OFF_BRG, 32'h4, ALL);
    $display("test map ended");
    // Pin functions
    wr(`CSP_OFF_MODE, 8'h01);
    repeat (2) @(posedge clk);
    check({30'h0, txd, txd_oe}, 32'h3);
    check({30'h0, clk_oe, sclk}, 32'h3);
    wr(`CSP_OFF_CTRL0, 8'h20);
    repeat (2) @(posedge clk);
    check(32'(txd_oe), 32'h0);
    wr(`CSP_OFF_MODE, 8'h09);
    repeat (2) @(posedge clk);
    check(32'(clk_oe), 32'h0);
    wr(`CSP_OFF_MODE, 8'h01);
    wr(`CSP_OFF_CTRL1, 8'h05);
    wr(`CSP_OFF_CTRL0, 8'h04);
    repeat (2) @(posedge clk);
    check({30'h0, flow_oe, flow_o}, 32'h2);
    wr(`CSP_OFF_CTRL0, 8'h10);
    repeat (2) @(posedge clk);
    check(32'(flow_oe), 32'h0);
    wr(`CSP_OFF_CTRL0, 8'h00);
    $display("test pins ended");
    // Held off by clear-to-send, then one frame
    pb <= 8'h3C;
    n0 = pfr;
    wr(`CSP_OFF_TXBUF, 8'hA5);
    repeat (30) @(posedge clk);
    rd(`CSP_OFF_CTRL1, 32'h5, ALL);
    flow_i <= 1'b0;
    fin();
    check({24'h0, pgot}, 32'hA5);
    check(32'(per), 32'hA);
    check(32'(evt_fr), 32'(n0));
    check(32'(rx_evts), 32'h1);
    rd(`CSP_OFF_CTRL1, 32'hF, ALL);
    rd(`CSP_OFF_RXBUF, 32'h3C, ALL);
    rd(`CSP_OFF_CTRL1, 32'h7, ALL);
    $display("test frame ended");
    // Event on completion, then inverted data
    wr(`CSP_OFF_CTRL1, 8'h15);
    xfer();
    check(32'(evt_fr), 32'(pfr));
    rd(`CSP_OFF_RXBUF, {24'h0, r}, ALL);
    wr(`CSP_OFF_CTRL1, 8'h45);
    xfer();
    check({24'h0, pgot}, {24'h0, ~t});
    rd(`CSP_OFF_RXBUF, {24'h0, ~r}, ALL);
    $display("test events ended");
    // Divided source, stalled while the idle alternate source is chosen
    wr(`CSP_OFF_CTRL1, 8'h05);
    wr(`CSP_OFF_CTRL0, 8'h01);
    wr(`CSP_OFF_CLKSRC, 8'h05);
    pb <= 8'h96;
    n0 = pfr;
    wr(`CSP_OFF_TXBUF, 8'h2D);
    repeat (200) @(posedge clk);
    check(32'(pfr), 32'(n0));
    wr(`CSP_OFF_CLKSRC, 8'h00);
    fin();
    check({24'h0, pgot}, 32'h2D);
    check(32'(per), 32'h14);
    rd(`CSP_OFF_RXBUF, 32'h96, ALL);
    wr(`CSP_OFF_CTRL0, 8'h00);
    $display("test source ended");
    // Overrun: second frame lands on an unread one
    wr(`CSP_OFF_CTRL1, 8'h05);
    xfer();
    k = rx_evts;
    xfer();
    check(32'(rx_evts), 32'(k));
    rd(`CSP_OFF_RXBUF, 32'h1000, 32'h1000);
    wr(`CSP_OFF_CTRL1, 8'h01);
    wr(`CSP_OFF_CTRL1, 8'h04);
    n0 = pfr;
    wr(`CSP_OFF_TXBUF, 8'h5A);
    repeat (40) @(posedge clk);
    check(32'(pfr), 32'(n0));
    rd(`CSP_OFF_RXBUF, 32'h0, 32'h1000);
    wr(`CSP_OFF_CTRL1, 8'h05);
    fin();
    check({24'h0, pgot}, 32'h5A);
    $display("test overrun ended");
    // Continuous receive started by buffer reads
    wr(`CSP_OFF_CTRL1, 8'h25);
    pb <= 8'hC3;
    n0 = pfr;
    rd(`CSP_OFF_RXBUF, {24'h0, r}, ALL);
    fin();
    pb <= 8'h81;
    n0 = pfr;
    rd(`CSP_OFF_RXBUF, 32'hC3, ALL);
    fin();
    wr(`CSP_OFF_CTRL1, 8'h05);
    rd(`CSP_OFF_RXBUF, 32'h81, ALL);
    $display("test continuous ended");
    // Frame clocked from the pin, clock idling high between edges
    wr(`CSP_OFF_MODE, 8'h09);
    wr(`CSP_OFF_TXBUF, 8'h00);
    repeat (8) begin
      ext_ck <= 1'b0;
      repeat (4) @(posedge clk);
      ext_ck <= 1'b1;
      repeat (4) @(posedge clk);
    end
    rd(`CSP_OFF_CTRL1, 32'hF, ALL);
    wr(`CSP_OFF_MODE, 8'h01);
    $display("test external ended");
    // Dual clock pins and flow separation
    wr(`CSP_OFF_SHARED, 8'h02);
    repeat (2) @(posedge clk);
    check({30'h0, flow_oe, flow_o}, 32'h3);
    wr(`CSP_OFF_CTRL0, 8'h40);
    repeat (2) @(posedge clk);
    check({30'h0, flow_oe, flow_o}, 32'h2);
    wr(`CSP_OFF_CTRL0, 8'h00);
    wr(`CSP_OFF_SHARED, 8'h03);
    repeat (2) @(posedge clk);
    check({30'h0, flow_oe, sclk}, 32'h3);
    wr(`CSP_OFF_SHARED, 8'h04);
    repeat (4) @(posedge clk);
    check({30'h0, sep_o, cts0_n}, 32'h2);
    flow_i <= 1'b1;
    repeat (4) @(posedge clk);
    check(32'(cts0_n), 32'h1);
    wr(`CSP_OFF_MODE, 8'h00);
    rd(`CSP_OFF_CTRL1, 32'h2, 32'h2);
    $display("test shared ended");
    give_verdict();
  end
endmodule : tb
